// ===== design/ccs_sequencer.v
`timescale 1ns/1ps
`include "ccs_defines.vh"
// Overview of operation
// - Drain allocating shareable transactions before maintenance
// - Dirty clean ops write back first, wait
// - Clean line with traffic ends not dirty
// - Invalidating ops drop local copy before issue
// - Issue maintenance only after all completions
// - CleanShared may evict or write unique line
// - Block allocating shareable requests until done
// - Write-backs keep snoop filter tracking correct
// - Maintenance attributes may differ from line's
// - Snooped master needs only ordinary behaviour
// - Attributes select targeted caches
// - Adapt attributes, outer shareable for all
// - Non-coherent updates unpredictable until invalidate
// - Domain codes 00 01 10 11
module ccs_sequencer #(
  parameter ADDR_W = 40
) (
  // Clock, reset, enable
  input wire clk,
  input wire reset,
  input wire clkEn,
  // Maintenance request from the processor side
  input wire reqValid,
  output wire reqReady,
  input wire [1:0] reqOp,
  input wire [ADDR_W-1:0] reqAddr,
  input wire [3:0] reqCache,
  input wire [1:0] reqDomain,
  input wire reqReachAll,
  output reg doneValid,
  // Local cache state of the target line
  output reg [ADDR_W-1:0] lookupAddr,
  input wire lineValid,
  input wire lineDirty,
  // Outstanding shareable allocating transactions to the target line
  input wire lineBusy,
  // Write-back or write-clean channel
  output reg wbValid,
  output reg wbClean,
  input wire wbReady,
  input wire wbDone,
  // Local invalidate strobe
  output reg invValid,
  // Maintenance request toward the interconnect
  output reg cmoValid,
  input wire cmoReady,
  output reg [1:0] cmoOp,
  output reg [ADDR_W-1:0] cmoAddr,
  output reg [3:0] cmoCache,
  output reg [1:0] cmoDomain,
  input wire cmoResp,
  // Blocking check for new allocating shareable requests
  input wire [ADDR_W-1:0] allocAddr,
  output wire allocBlock,
  output wire [2:0] seqState
);
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [1:0] op_r;
  reg active_r;
  wire [3:0] adCache;
  wire [1:0] adDomain;
  wire isClean;
  wire isInval;

  assign isClean = (op_r == `CCS_OP_CLEAN_SHARED) ||
                   (op_r == `CCS_OP_CLEAN_INVALID);
  assign isInval = (op_r == `CCS_OP_CLEAN_INVALID) ||
                   (op_r == `CCS_OP_MAKE_INVALID);
  // Ready only while running, so a frozen block cannot lose a request
  assign reqReady = (state_r == `CCS_ST_IDLE) && clkEn;
  assign seqState = state_r;
  // Address match blocks allocation for the whole sequence; snoops are
  // not gated here and keep their ordinary handling
  assign allocBlock = active_r && (allocAddr == lookupAddr);

  ccs_attr_adapt uAdapt (
    .instCache(reqCache),
    .instDomain(reqDomain),
    .reachAll(reqReachAll),
    .cmoCache(adCache),
    .cmoDomain(adDomain)
  );

  // Next-state: drain, write back, invalidate, issue, wait response
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `CCS_ST_IDLE: begin
        if (reqValid) begin
          state_nxt = `CCS_ST_DRAIN;
        end
      end
      `CCS_ST_DRAIN: begin
        // Dirty is re-sampled after drain so late fills are caught; the
        // line may flip while a non-coherent agent owns it
        if (!lineBusy) begin
          if (isClean && lineValid && lineDirty) begin
            state_nxt = `CCS_ST_WBREQ;
          end else if (isInval && lineValid) begin
            state_nxt = `CCS_ST_INVAL;
          end else begin
            state_nxt = `CCS_ST_ISSUE;
          end
        end
      end
      `CCS_ST_WBREQ: begin
        if (wbReady) begin
          state_nxt = `CCS_ST_WBWAIT;
        end
      end
      `CCS_ST_WBWAIT: begin
        if (wbDone) begin
          state_nxt = isInval ? `CCS_ST_INVAL : `CCS_ST_ISSUE;
        end
      end
      `CCS_ST_INVAL: begin
        state_nxt = `CCS_ST_ISSUE;
      end
      `CCS_ST_ISSUE: begin
        if (cmoReady) begin
          state_nxt = `CCS_ST_WAIT;
        end
      end
      `CCS_ST_WAIT: begin
        if (cmoResp) begin
          state_nxt = `CCS_ST_IDLE;
        end
      end
      default: begin
        state_nxt = `CCS_ST_IDLE;
      end
    endcase
  end

  // State register; the clock enable freezes the whole sequence
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= `CCS_ST_IDLE;
    end else if (clkEn) begin
      state_r <= state_nxt;
    end
  end

  // Capture the request and its adapted attributes at acceptance
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      op_r <= `CCS_OP_CLEAN_SHARED;
      lookupAddr <= {ADDR_W{1'b0}};
      cmoOp <= `CCS_OP_CLEAN_SHARED;
      cmoAddr <= {ADDR_W{1'b0}};
      cmoCache <= `CCS_CACHE_NONE;
      cmoDomain <= `CCS_DOM_NON_SHARE;
    end else if (clkEn && state_r == `CCS_ST_IDLE && reqValid) begin
      op_r <= reqOp;
      lookupAddr <= reqAddr;
      cmoOp <= reqOp;
      cmoAddr <= reqAddr;
      cmoCache <= adCache;
      cmoDomain <= adDomain;
    end
  end

  // CleanShared keeps the line, so write-clean; else write back
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wbValid <= 1'b0;
      wbClean <= 1'b0;
    end else if (clkEn) begin
      if (state_nxt == `CCS_ST_WBREQ && state_r != `CCS_ST_WBREQ) begin
        wbValid <= 1'b1;
        wbClean <= (op_r == `CCS_OP_CLEAN_SHARED);
      end else if (state_r == `CCS_ST_WBREQ && wbReady) begin
        wbValid <= 1'b0;
      end
    end
  end

  // One-cycle local invalidate, only once drain and write-back are over
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      invValid <= 1'b0;
    end else if (clkEn) begin
      invValid <= (state_nxt == `CCS_ST_INVAL);
    end
  end

  // Maintenance request raised on entry to issue, held until taken
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cmoValid <= 1'b0;
    end else if (clkEn) begin
      if (state_nxt == `CCS_ST_ISSUE && state_r != `CCS_ST_ISSUE) begin
        cmoValid <= 1'b1;
      end else if (state_r == `CCS_ST_ISSUE && cmoReady) begin
        cmoValid <= 1'b0;
      end
    end
  end

  // Sequence stays active, blocking allocation, until the response
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      active_r <= 1'b0;
      doneValid <= 1'b0;
    end else if (clkEn) begin
      doneValid <= 1'b0;
      if (state_r == `CCS_ST_IDLE && reqValid) begin
        active_r <= 1'b1;
      end
      if (state_r == `CCS_ST_WAIT && cmoResp) begin
        active_r <= 1'b0;
        doneValid <= 1'b1;
      end
    end
  end
endmodule

// ===== design/ccs_defines.vh
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH
// Maintenance operation codes on the request side
`define CCS_OP_CLEAN_SHARED 2'h0
`define CCS_OP_CLEAN_INVALID 2'h1
`define CCS_OP_MAKE_INVALID 2'h2
// Two-bit domain attribute
`define CCS_DOM_NON_SHARE 2'h0
`define CCS_DOM_INNER 2'h1
`define CCS_DOM_OUTER 2'h2
`define CCS_DOM_SYSTEM 2'h3
// Cache attribute used for maintenance that must reach every cache
`define CCS_CACHE_ALL 4'hf
// Cache attribute held while no request has been captured
`define CCS_CACHE_NONE 4'h0
// Sequencer states
`define CCS_ST_IDLE 3'h0
`define CCS_ST_DRAIN 3'h1
`define CCS_ST_WBREQ 3'h2
`define CCS_ST_WBWAIT 3'h3
`define CCS_ST_INVAL 3'h4
`define CCS_ST_ISSUE 3'h5
`define CCS_ST_WAIT 3'h6
`endif

// ===== design/ccs_attr_adapt.v
`timescale 1ns/1ps
`include "ccs_defines.vh"
// Adapts instruction attributes so the maintenance reaches the needed caches
module ccs_attr_adapt (
  // Instruction attributes
  input wire [3:0] instCache,
  input wire [1:0] instDomain,
  input wire reachAll,
  // Adapted attributes
  output reg [3:0] cmoCache,
  output reg [1:0] cmoDomain
);
  // Outer shareable is the most pervasive maintenance domain
  always @* begin
    cmoCache = instCache;
    cmoDomain = instDomain;
    if (reachAll) begin
      cmoCache = `CCS_CACHE_ALL;
      cmoDomain = `CCS_DOM_OUTER;
    end
  end
endmodule

// ===== sim/ccs_checker.sv
`timescale 1ns/1ps
// clkEn is held high by the bench, so no freeze terms appear here
module ccs_checker #(parameter ADDR_W = 40) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Handshakes and line state
  input wire reqValid,
  input wire reqReady,
  input wire reqReachAll,
  input wire doneValid,
  input wire lineValid,
  input wire lineBusy,
  input wire lineDirty,
  input wire wbValid,
  input wire invValid,
  input wire cmoValid,
  input wire cmoReady,
  input wire cmoResp,
  input wire allocBlock,
  // Buses
  input wire [1:0] cmoOp,
  input wire [1:0] cmoDomain,
  input wire [3:0] cmoCache,
  input wire [2:0] seqState,
  input wire [ADDR_W-1:0] cmoAddr,
  input wire [ADDR_W-1:0] lookupAddr,
  input wire [ADDR_W-1:0] allocAddr
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_ready_idle: assert property (reqReady == (seqState == 3'h0))
    else $error("ready");
  a_busy_stall: assert property (seqState == 3'h1 && lineBusy |=>
    seqState == 3'h1) else $error("stall");
  a_dirty_wb: assert property (seqState == 3'h1 && !lineBusy
    && lineValid && lineDirty && cmoOp != 2'h2 |=> wbValid &&
    seqState == 3'h2) else $error("wb");
  a_inv_issue: assert property (invValid |=> seqState == 3'h5)
    else $error("inv");
  a_alloc_blk: assert property (allocBlock ==
    (seqState != 3'h0 && allocAddr == lookupAddr)) else $error("alloc");
  a_done_cause: assert property (doneValid |-> $past(cmoResp) &&
    $past(seqState) == 3'h6) else $error("done");
  a_reach_all: assert property (reqValid && reqReady && reqReachAll |->
    ##[2:40] cmoValid && cmoDomain == 2'h2 && cmoCache == 4'hf)
    else $error("reach");
  a_cmo_hold: assert property (cmoValid && !cmoReady |=>
    cmoValid && $stable(cmoAddr)) else $error("hold");
  c_inv: cover property (invValid);
  c_wb: cover property (wbValid && seqState == 3'h2);
  c_done: cover property (doneValid);
endmodule
bind ccs_sequencer ccs_checker #(.ADDR_W(ADDR_W)) chk (.*);

// ===== sim/ccs_icn_model.sv
`timescale 1ns/1ps
// Interconnect stand-in; slow only accepts on every other cycle
module ccs_icn_model (
  // Clock, reset and pacing
  input wire clk,
  input wire reset,
  input wire slow,
  // Requests from the sequencer
  input wire wbValid,
  input wire cmoValid,
  // Acceptance and completion
  output reg wbReady,
  output reg wbDone,
  output reg cmoReady,
  output reg cmoResp
);
  reg tick_r;
  // Ready drops after each handshake; completion follows one cycle later
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      {tick_r, wbReady, wbDone, cmoReady, cmoResp} <= 5'h0;
    end else begin
      tick_r <= ~tick_r;
      wbReady <= wbValid && !wbReady && (!slow || tick_r);
      wbDone <= wbValid && wbReady;
      cmoReady <= cmoValid && !cmoReady && (!slow || tick_r);
      cmoResp <= cmoValid && cmoReady;
    end
  end
endmodule

// ===== sim/coherent_cmo_sequencer_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmpCount++; if ((e) !== (g)) begin failures++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module coherent_cmo_sequencer_tb_top;
  reg clk = 0, reset = 1, reqValid = 0, reqReachAll = 0, lineValid = 0;
  reg lineDirty = 0, lineBusy = 0, slow = 0, wbN = 0, ivN = 0;
  reg [1:0] reqOp = 0, reqDomain = 0;
  reg [3:0] reqCache = 0;
  reg [39:0] reqAddr = 0, allocAddr = 0;
  reg [15:0] lf = 16'h125f;
  reg [49:0] expQ[$], e;
  integer failures = 0, cmpCount = 0, i;
  wire reqReady, doneValid, wbValid, wbClean, wbReady, wbDone, invValid;
  wire cmoValid, cmoReady, cmoResp, allocBlock;
  wire [1:0] cmoOp, cmoDomain;
  wire [3:0] cmoCache;
  wire [2:0] seqState;
  wire [39:0] lookupAddr, cmoAddr;
  wire [49:0] obs = {cmoOp, cmoAddr, cmoCache, cmoDomain, wbN, ivN};
  initial forever #2 clk = ~clk;
  ccs_sequencer uut (.clkEn(1'b1), .*);
  ccs_icn_model icn (.*);
  function [15:0] nx(input [15:0] s);
    nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Dirty is only known once busy drops, so it is set late
  task run(input [1:0] op, input v, input d, input all);
    integer k;
    begin
      lf = nx(lf);
      reqOp <= op;
      reqAddr <= {24'h0, lf};
      reqCache <= lf[3:0];
      reqDomain <= lf[5:4];
      reqReachAll <= all;
      reqValid <= 1;
      lineValid <= v;
      lineDirty <= v & d & ~lf[8];
      lineBusy <= lf[8];
      allocAddr <= lf[9] ? {24'h0, lf} : 40'h0;
      slow <= lf[10];
      expQ.push_back({op, 24'h0, lf, all ? 4'hf : lf[3:0],
        all ? 2'h2 : lf[5:4], v & d & (op != 2'h2), v & (op != 2'h0)});
      @(posedge clk);
      reqValid <= 0;
      repeat (lf[8] ? lf[13:11] : 3'h0) @(posedge clk);
      lineDirty <= v & d;
      lineBusy <= 0;
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (doneValid !== 1'b1 && k < 80);
      if (doneValid !== 1'b1) begin
        failures++;
        end_sim;
      end
      @(posedge clk);
    end
  endtask
  // Scoreboard: oldest note is matched when the interconnect takes a request
  always @(posedge clk) if (!reset) begin
    if (reqValid && reqReady) {wbN, ivN} <= 2'h0;
    if (wbValid && wbReady) begin
      wbN <= 1;
      `CHK("wbClean", expQ[0][49:48] == 2'h0, wbClean)
    end
    if (invValid) ivN <= 1;
    if (cmoValid && cmoReady) begin
      e = expQ.pop_front();
      `CHK("cmo", e, obs)
      `CHK("allocBlock", allocAddr == reqAddr, allocBlock)
    end
    if (doneValid) `CHK("allocIdle", 1'b0, allocBlock)
  end
  task end_sim;
    begin
      if (failures == 0 && cmpCount > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset <= 0;
    // Clean, clean-invalidate, make-invalid rotate per line
    // Each sequence completes before the next line access starts
    for (i = 0; i < 30; i++) run(2'(i % 3), i < 12 || lf[0], i[2], i[3]);
    end_sim;
  end
endmodule
